// >>> src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Register offsets as seen through the pointer.
  localparam logic [7:0] CMD_ADDR = 8'h00;
  localparam logic [7:0] RESULT_ADDR = 8'h01;
  localparam logic [7:0] SEQ_ADDR = 8'h08;
  localparam logic [7:0] CFG_ADDR = 8'h09;

  // Reset values of the writable registers.
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] SEQ_RESET = 8'h00;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Configuration bit that enables background conversions.
  localparam int CFG_AUTO_BIT = 12;

  // Default seven bit bus address of the slave port.
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h61;

  // Core clock period and the timing figures derived from it.
  localparam int CLK_PERIOD_NS = 100;
  localparam int CMD_TIMEOUT_MS = 5;
  localparam int AUTO_PERIOD_US = 50;
  localparam int CMD_TIMEOUT_CYC = (CMD_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int AUTO_PERIOD_CYC = (AUTO_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  // Depth of the result buffer between converter and result register.
  localparam int FIFO_DEPTH = 8;

  // Write phases of a bus write transaction.
  typedef enum logic [1:0] {
    WR_POINTER,
    WR_FIRST,
    WR_SECOND
  } write_phase_type;

  // One finished conversion as it appears in the result register.
  typedef struct packed {
    logic alert;
    logic [2:0] chan;
    logic [11:0] data;
  } result_word_type;

endpackage

// >>> src/adc_conversion_mode_and_readback.sv
// How it works
// - Pointer serves unlimited reads without rewrite.
// - Pointer survives a stop condition.
// - On master NACK, device releases data line.
// - 8-bit register repeats its byte every slot.
// - 16-bit register returns unlimited two-byte lots.
// - Result bytes: alert, channel, twelve result bits.
// - Command write enters command mode, starts conversion.
// - Next conversion starts when a result lot begins.
// - Each command bit selects one channel.
// - Sequence wraps to first channel after last.
// - NACK then stop leaves command mode.
// - Stop instead of repeated start leaves command mode.
// - Pointer restored after command; following pointer byte accepted.
// - Five milliseconds without read leaves command mode.
// - New command write replaces the sequence.
// - Autocycle converts the next sequence channel every fifty microseconds.
// - Bus always served; result holds latest conversion.
// - Autocycle off at reset, enabled by configuration bit.
// - Command and sequence registers take one byte.
// - Sixteen-bit writes arrive upper byte first.
`timescale 1ns/1ps

// Small flip-flop FIFO that holds finished conversions until they can be shown.
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage entries.
  logic [AW-1:0] wr_q; // Write index.
  logic [AW-1:0] rd_q; // Read index.
  logic [AW:0] count_q; // Number of stored words.
  logic push; // A word enters this cycle.
  logic pop; // A word leaves this cycle.

  assign in_ready_o = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Entry storage is written at the write index.
  always_ff @(posedge core_clk_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Indices wrap at the configured depth.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Bus slave, command and autocycle sequencer and result read-back.
module adc_conversion_mode_and_readback #(
  parameter logic [6:0] SLAVE_ADDR = adc_ctrl_pkg::SLAVE_ADDR_DEFAULT,
  parameter int TIMEOUT_CYC = adc_ctrl_pkg::CMD_TIMEOUT_CYC,
  parameter int DEPTH = adc_ctrl_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic conv_start_o,
  output logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  input wire logic conv_alert_i,
  output logic cmd_mode_o,
  output logic auto_mode_o
);
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } bus_state_type;

  bus_state_type state_q; // Bus transaction state.
  logic [2:0] scl_sync_q; // Clock line synchroniser and edge history.
  logic [2:0] sda_sync_q; // Data line synchroniser and edge history.
  logic scl_rise, scl_fall, start_cond, stop_cond; // Decoded bus events.
  logic [7:0] rx_q; // Received byte.
  logic [7:0] tx_q; // Byte being shifted out.
  logic [2:0] bit_q; // Bit count within a byte.
  logic got_q; // Eight bits have passed.
  logic rw_q; // Direction bit of the current transaction.
  logic ack_q; // Master acknowledged the byte just sent.
  logic oe_q; // Data line pull-down.
  logic [7:0] ptr_q; // Register pointer.
  logic [7:0] prev_ptr_q; // Pointer to restore after a command write.
  adc_ctrl_pkg::write_phase_type phase_q; // Position within a write.
  logic [7:0] hi_q; // Held upper byte of a 16-bit write.
  logic hi_next_q; // Next 16-bit read slot is the upper byte.
  logic [7:0] lo_q; // Lower byte latched when a lot starts.
  logic lot_open_q; // Upper byte sent, lower byte pending.
  logic [7:0] cmd_seq_q; // Command mode channel selection.
  logic [7:0] seq_q; // Autocycle channel selection.
  logic [15:0] cfg_q; // Configuration register.
  logic [15:0] result_q; // Result register.
  logic cmd_mode_q; // Command mode active.
  logic [2:0] chan_q; // Channel of the conversion last started.
  logic [2:0] pchan_q; // Channel chosen for the next start.
  logic pend_q; // A conversion is requested but not started.
  logic busy_q; // Converter is working.
  logic start_q; // Start pulse register.
  logic [adc_ctrl_pkg::TIMER_W-1:0] idle_q; // Cycles since last read.
  logic [adc_ctrl_pkg::TIMER_W-1:0] tick_q; // Autocycle period timer.
  logic auto_on; // Background conversions active.
  logic byte_rx; // A write byte is complete at this falling edge.
  logic read_start; // A read transaction is acknowledged.
  logic load_byte; // A new read byte is loaded at this falling edge.
  logic [7:0] rd_byte; // Byte the pointer selects for this slot.
  logic req_cmd_first; // Command write completes.
  logic req_next; // Next command or autocycle conversion wanted.
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready; // Buffer handshakes.
  adc_ctrl_pkg::result_word_type fifo_in, fifo_out; // Buffer words.

  // Finds the next selected channel after cur, wrapping round the sequence.
  function automatic logic [2:0] next_chan(input logic [7:0] seq, input logic [2:0] cur);
    logic [2:0] idx;
    logic found;
    next_chan = cur;
    found = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      idx = cur + 3'(k);
      if (!found && seq[idx]) begin
        next_chan = idx;
        found = 1'b1;
      end
    end
  endfunction

  // Two flip-flops for each bus pin before any logic looks at them.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else if (ce_i) begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
    end
  end

  assign scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  assign start_cond = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[1] && sda_sync_q[2];
  assign stop_cond = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[1] && !sda_sync_q[2];
  assign byte_rx = (state_q == ST_WR) && scl_fall && got_q;
  assign read_start = (state_q == ST_ADDR_ACK) && scl_fall && rw_q;
  assign load_byte = read_start || ((state_q == ST_RD_ACK) && scl_fall && ack_q);
  assign auto_on = cfg_q[adc_ctrl_pkg::CFG_AUTO_BIT] && (seq_q != '0) && !cmd_mode_q;

  // Selects the byte for the current read slot.
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr_q)
      adc_ctrl_pkg::CMD_ADDR: rd_byte = cmd_seq_q;
      adc_ctrl_pkg::SEQ_ADDR: rd_byte = seq_q;
      adc_ctrl_pkg::RESULT_ADDR: rd_byte = hi_next_q ? result_q[15:8] : lo_q;
      adc_ctrl_pkg::CFG_ADDR: rd_byte = hi_next_q ? cfg_q[15:8] : lo_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // Bus state machine: framing, acknowledge and data shifting.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      rx_q <= '0;
      tx_q <= '0;
      bit_q <= '0;
      got_q <= 1'b0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ce_i) begin
      if (start_cond) begin
        // A start or repeated start always begins an address byte.
        state_q <= ST_ADDR;
        bit_q <= '0;
        got_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (stop_cond) begin
        state_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            oe_q <= 1'b0;
          end
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              rx_q <= {rx_q[6:0], sda_sync_q[1]};
              bit_q <= bit_q + 3'h1;
              got_q <= (bit_q == 3'h7);
            end else if (scl_fall && got_q) begin
              got_q <= 1'b0;
              if (state_q == ST_WR) begin
                oe_q <= 1'b1;
                state_q <= ST_WR_ACK;
              end else if (rx_q[7:1] == SLAVE_ADDR) begin
                oe_q <= 1'b1;
                rw_q <= rx_q[0];
                state_q <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              oe_q <= 1'b0;
              state_q <= ST_WR;
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                oe_q <= !rd_byte[7];
                tx_q <= {rd_byte[6:0], 1'b0};
                state_q <= ST_RD;
              end else begin
                oe_q <= 1'b0;
                state_q <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_q <= bit_q + 3'h1;
              got_q <= (bit_q == 3'h7);
            end else if (scl_fall) begin
              if (got_q) begin
                got_q <= 1'b0;
                oe_q <= 1'b0;
                state_q <= ST_RD_ACK;
              end else begin
                oe_q <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              ack_q <= !sda_sync_q[1];
            end else if (scl_fall) begin
              if (ack_q) begin
                oe_q <= !rd_byte[7];
                tx_q <= {rd_byte[6:0], 1'b0};
                state_q <= ST_RD;
              end else begin
                oe_q <= 1'b0;
                state_q <= ST_IDLE;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Pointer and write phase; the pointer is set by a pointer byte and restored after a command byte.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= adc_ctrl_pkg::PTR_RESET;
      prev_ptr_q <= adc_ctrl_pkg::PTR_RESET;
      phase_q <= adc_ctrl_pkg::WR_POINTER;
      hi_q <= '0;
    end else if (ce_i) begin
      if (start_cond) begin
        phase_q <= adc_ctrl_pkg::WR_POINTER;
      end else if (byte_rx) begin
        unique case (phase_q)
          adc_ctrl_pkg::WR_POINTER: begin
            prev_ptr_q <= ptr_q;
            ptr_q <= rx_q;
            phase_q <= adc_ctrl_pkg::WR_FIRST;
          end
          adc_ctrl_pkg::WR_FIRST: begin
            if (ptr_q == adc_ctrl_pkg::RESULT_ADDR || ptr_q == adc_ctrl_pkg::CFG_ADDR) begin
              hi_q <= rx_q;
              phase_q <= adc_ctrl_pkg::WR_SECOND;
            end else begin
              phase_q <= adc_ctrl_pkg::WR_POINTER;
              if (ptr_q == adc_ctrl_pkg::CMD_ADDR) begin
                ptr_q <= prev_ptr_q;
              end
            end
          end
          adc_ctrl_pkg::WR_SECOND: phase_q <= adc_ctrl_pkg::WR_POINTER;
          default: phase_q <= adc_ctrl_pkg::WR_POINTER;
        endcase
      end
    end
  end

  // Plain register writes from the bus.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_q <= adc_ctrl_pkg::SEQ_RESET;
      cfg_q <= adc_ctrl_pkg::CFG_RESET;
    end else if (ce_i && byte_rx) begin
      if (phase_q == adc_ctrl_pkg::WR_FIRST && ptr_q == adc_ctrl_pkg::SEQ_ADDR) begin
        seq_q <= rx_q;
      end
      if (phase_q == adc_ctrl_pkg::WR_SECOND && ptr_q == adc_ctrl_pkg::CFG_ADDR) begin
        cfg_q <= {hi_q, rx_q};
      end
    end
  end

  assign req_cmd_first = byte_rx && phase_q == adc_ctrl_pkg::WR_FIRST
    && ptr_q == adc_ctrl_pkg::CMD_ADDR && rx_q != 8'h00;

  // Read slot bookkeeping: upper then lower byte of each 16-bit lot.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_next_q <= 1'b1;
      lo_q <= '0;
      lot_open_q <= 1'b0;
    end else if (ce_i) begin
      if (read_start) begin
        hi_next_q <= 1'b0;
        lot_open_q <= 1'b1;
        lo_q <= (ptr_q == adc_ctrl_pkg::CFG_ADDR) ? cfg_q[7:0] : result_q[7:0];
      end else if (load_byte) begin
        hi_next_q <= !hi_next_q;
        lot_open_q <= hi_next_q;
        if (hi_next_q) begin
          lo_q <= (ptr_q == adc_ctrl_pkg::CFG_ADDR) ? cfg_q[7:0] : result_q[7:0];
        end
      end else if (start_cond || stop_cond) begin
        hi_next_q <= 1'b1;
        lot_open_q <= 1'b0;
      end
    end
  end

  // Command mode: entry on command write, exit on stop or read timeout.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_mode_q <= 1'b0;
      cmd_seq_q <= '0;
      idle_q <= '0;
    end else if (ce_i) begin
      if (byte_rx && phase_q == adc_ctrl_pkg::WR_FIRST && ptr_q == adc_ctrl_pkg::CMD_ADDR) begin
        cmd_seq_q <= rx_q;
        cmd_mode_q <= (rx_q != 8'h00);
        idle_q <= '0;
      end else if (stop_cond) begin
        cmd_mode_q <= 1'b0;
      end else if (cmd_mode_q) begin
        if (read_start) begin
          idle_q <= '0;
        end else if (idle_q >= adc_ctrl_pkg::TIMER_W'(TIMEOUT_CYC - 1)) begin
          cmd_mode_q <= 1'b0;
          idle_q <= '0;
        end else begin
          idle_q <= idle_q + 1'b1;
        end
      end
    end
  end

  // Autocycle timer raises a request once per period while enabled.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_q <= '0;
    end else if (ce_i) begin
      if (!auto_on || tick_q >= adc_ctrl_pkg::TIMER_W'(adc_ctrl_pkg::AUTO_PERIOD_CYC - 1)) begin
        tick_q <= '0;
      end else begin
        tick_q <= tick_q + 1'b1;
      end
    end
  end

  // A lot start on the result register in command mode asks for the next channel.
  assign req_next = (cmd_mode_q && load_byte && hi_next_q && ptr_q == adc_ctrl_pkg::RESULT_ADDR)
    || (auto_on && tick_q == adc_ctrl_pkg::TIMER_W'(adc_ctrl_pkg::AUTO_PERIOD_CYC - 1));

  // Conversion launcher; waits for the converter and for buffer room.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_q <= '0;
      pchan_q <= '0;
      pend_q <= 1'b0;
      busy_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ce_i) begin
      start_q <= 1'b0;
      if (req_cmd_first) begin
        pchan_q <= next_chan(rx_q, 3'h7);
        pend_q <= 1'b1;
      end else if (req_next) begin
        pchan_q <= next_chan(cmd_mode_q ? cmd_seq_q : seq_q, pchan_q);
        pend_q <= 1'b1;
      end else if (pend_q && !busy_q && fifo_in_ready) begin
        pend_q <= 1'b0;
        busy_q <= 1'b1;
        start_q <= 1'b1;
        // The channel moves only with a start, so a running conversion keeps its tag.
        chan_q <= pchan_q;
      end
      if (conv_done_i) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign fifo_in = '{alert: conv_alert_i, chan: conv_chan_o, data: conv_data_i};
  // The result register holds still from a lot start until the lot's lower byte is loaded.
  assign fifo_out_ready = !lot_open_q;

  result_fifo #(
    .WIDTH($bits(adc_ctrl_pkg::result_word_type)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .in_data_i(fifo_in),
    .in_valid_i(conv_done_i),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready)
  );

  // Result register: bus write or the oldest buffered finished conversion.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_q <= adc_ctrl_pkg::RESULT_RESET;
    end else if (ce_i) begin
      if (byte_rx && phase_q == adc_ctrl_pkg::WR_SECOND && ptr_q == adc_ctrl_pkg::RESULT_ADDR) begin
        result_q <= {hi_q, rx_q};
      end else if (fifo_out_valid && fifo_out_ready) begin
        result_q <= fifo_out;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign conv_start_o = start_q;
  assign conv_chan_o = chan_q;
  assign cmd_mode_o = cmd_mode_q;
  assign auto_mode_o = auto_on;
endmodule

// >>> testbench/adc_ctrl_properties.sv
`timescale 1ns/1ps

// Watches the bus pins, converter handshake and mode flags.
module adc_ctrl_properties #(
  parameter int TIMEOUT_CYC = 50000
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic cmd_mode_o,
  input wire logic auto_mode_o
);
  logic busy_q; // A conversion is outstanding.
  logic scl_q; // Bus clock one cycle ago.
  logic [19:0] idle_q; // Command mode cycles since a bus clock fall.
  logic [9:0] gap_q; // Autocycle cycles since the last request.

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Tracks the one outstanding conversion.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
    end else if (conv_start_o) begin
      busy_q <= 1'b1;
    end else if (conv_done_i) begin
      busy_q <= 1'b0;
    end
  end

  // Counts quiet command time and autocycle request gaps while the block is enabled.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      idle_q <= 20'h0;
      gap_q <= 10'h0;
    end else if (ce_i) begin
      scl_q <= scl_i;
      idle_q <= (cmd_mode_o && !(scl_q && !scl_i)) ? idle_q + 20'h1 : 20'h0;
      gap_q <= (auto_mode_o && !conv_start_o) ? gap_q + 10'h1 : 10'h0;
    end
  end

  a_cmd_starts: assert property ($rose(cmd_mode_o) |-> ##[1:6] conv_start_o)
    else $error("command entry without a conversion request");
  a_one_pending: assert property (conv_start_o |-> !busy_q)
    else $error("request while a conversion is outstanding");
  a_chan_with_start: assert property ($changed(conv_chan_o) |-> conv_start_o)
    else $error("channel moved without a request");
  a_modes_apart: assert property (cmd_mode_o |-> !auto_mode_o)
    else $error("both modes active");
  a_start_in_mode: assert property (conv_start_o |-> cmd_mode_o || auto_mode_o
    || $past(cmd_mode_o) || $past(auto_mode_o))
    else $error("request outside any mode");
  a_cmd_timeout: assert property (idle_q <= TIMEOUT_CYC + 8)
    else $error("command mode outlived its timeout");
  a_auto_rate: assert property (gap_q < 10'd600)
    else $error("autocycle request overdue");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while bus clock high");
  a_stop_exits: assert property (cmd_mode_o && scl_i && $rose(sda_i) |-> ##[1:8] !cmd_mode_o)
    else $error("stop did not end command mode");

  c_cmd_entry: cover property ($rose(cmd_mode_o));
  c_auto_request: cover property (auto_mode_o && conv_start_o);
  c_timeout_exit: cover property ($fell(cmd_mode_o) && !scl_i);
endmodule

bind adc_conversion_mode_and_readback adc_ctrl_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .ce_i(ce_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_oe_o(sda_oe_o),
  .conv_start_o(conv_start_o),
  .conv_chan_o(conv_chan_o),
  .conv_done_i(conv_done_i),
  .cmd_mode_o(cmd_mode_o),
  .auto_mode_o(auto_mode_o)
);

// >>> testbench/i2c_master_model.sv
`timescale 1ns/1ps

// Bus master that works the two open-drain lines.
module i2c_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Both lines start released.
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Waits whole cycles, then steps just past the edge.
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask

  // One bit slot; data moves only while the clock is low.
  task automatic bit_io(input logic b, output logic r);
    w(1);
    sda_oe_o = !b;
    w(5);
    scl_o = 1'b1;
    w(6);
    r = sda_i;
    scl_o = 1'b0;
  endtask

  // Start or repeated start.
  task automatic start();
    w(1);
    sda_oe_o = 1'b0;
    w(5);
    scl_o = 1'b1;
    w(6);
    sda_oe_o = 1'b1;
    w(6);
    scl_o = 1'b0;
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    w(1);
    sda_oe_o = 1'b1;
    w(5);
    scl_o = 1'b1;
    w(6);
    sda_oe_o = 1'b0;
    w(6);
  endtask

  // Sends a byte upper bit first; returns the acknowledge.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Receives a byte; answers with an acknowledge only when ack is set.
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// >>> testbench/adc_conversion_mode_and_readback_tb.sv
`timescale 1ns/1ps

// Exercises register reads, autocycle and command mode over the bus.
module adc_conversion_mode_and_readback_tb;
  localparam int TMO = 600; // Shortened command timeout.
  localparam logic [6:0] SA = adc_ctrl_pkg::SLAVE_ADDR_DEFAULT;
  localparam logic [2:0] SEQ13 [4] = '{3'h0, 3'h1, 3'h4, 3'h0};
  logic core_clk_i, nrst_i, ce_i, conv_done_i, conv_alert_i, scl_m, oe_m;
  logic sda_o, sda_oe_o, conv_start_o, cmd_mode_o, auto_mode_o;
  logic [11:0] conv_data_i;
  logic [2:0] conv_chan_o, ch;
  wire sda_w = !(sda_oe_o | oe_m); // Wired-and bus line with pull-up.
  int err_total, total_checks;
  logic [7:0] q [$]; // Bytes of the last read.
  logic [2:0] chs [$]; // Channels requested from the converter.

  // 10 MHz core clock.
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = !core_clk_i;
  end

  adc_conversion_mode_and_readback #(.TIMEOUT_CYC(TMO)) uut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .scl_i(scl_m),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .conv_alert_i(conv_alert_i), .cmd_mode_o(cmd_mode_o), .auto_mode_o(auto_mode_o));
  i2c_master_model m (.clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl_m), .sda_oe_o(oe_m));

  // Converter stand-in answering each request after 30 cycles.
  initial begin
    conv_done_i = 1'b0;
    conv_data_i = 12'h000;
    conv_alert_i = 1'b0;
    forever begin
      m.w(1);
      if (conv_start_o === 1'b1) begin
        ch = conv_chan_o;
        chs.push_back(ch);
        repeat (30) @(posedge core_clk_i);
        #10;
        conv_data_i = {9'h0a5, ch};
        conv_alert_i = ch[0];
        conv_done_i = 1'b1;
        m.w(1);
        conv_done_i = 1'b0;
        conv_data_i = ~conv_data_i;
      end
    end
  end

  // Result word the converter stand-in yields for a channel.
  function automatic logic [15:0] ew(input logic [2:0] c);
    return {c[0], c, 9'h0a5, c};
  endfunction

  // Upper and lower byte of lot k of the last read.
  function automatic logic [15:0] lot(input int k);
    return {q[2*k], q[2*k+1]};
  endfunction

  // Compares and counts.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write transaction; keep leaves the bus held for a repeated start.
  task automatic wr(input logic [7:0] b [$], input logic keep);
    logic a;
    m.start();
    m.wr_byte({SA, 1'b0}, a);
    chk(16'(a), 16'h0001);
    foreach (b[i]) begin
      m.wr_byte(b[i], a);
      chk(16'(a), 16'h0001);
    end
    if (!keep) begin
      m.stop();
    end
  endtask

  // Read transaction of n bytes into q.
  task automatic rd(input int n);
    logic a;
    logic [7:0] b;
    q = {};
    m.start();
    m.wr_byte({SA, 1'b1}, a);
    chk(16'(a), 16'h0001);
    for (int i = 0; i < n; i++) begin
      m.rd_byte(i < n - 1, b);
      q.push_back(b);
    end
    m.stop();
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge core_clk_i);
    err_total++;
    final_report();
  end

  initial begin
    err_total = 0;
    total_checks = 0;
    ce_i = 1'b1;
    nrst_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    #10;
    nrst_i = 1'b1;
    m.w(5);
    wr({8'h09, 8'h02, 8'h34}, 1'b0);
    wr({8'h08, 8'h05}, 1'b0);
    rd(3);
    foreach (q[i]) chk(16'(q[i]), 16'h0005);
    rd(1);
    chk(16'(q[0]), 16'h0005);
    wr({8'h09}, 1'b0);
    rd(4);
    chk(lot(0), 16'h0234);
    chk(lot(1), 16'h0234);
    $display("register test done");
    chs = {};
    wr({8'h09, 8'h12, 8'h34}, 1'b0);
    chk(16'(auto_mode_o), 16'h0001);
    m.w(1200);
    chk(16'(chs[0]), 16'h0002);
    chk(16'(chs[1]), 16'h0000);
    wr({8'h01}, 1'b0);
    rd(2);
    chk(lot(0), ew(q[0][6:4]));
    wr({8'h08, 8'h00}, 1'b0);
    chk(16'(auto_mode_o), 16'h0000);
    m.w(100);
    $display("autocycle test done");
    wr({8'h00, 8'h13, 8'h01}, 1'b1);
    m.w(8);
    chk(16'(cmd_mode_o), 16'h0001);
    rd(8);
    for (int i = 0; i < 4; i++) chk(lot(i), ew(SEQ13[i]));
    chk(16'(cmd_mode_o), 16'h0000);
    chs = {};
    wr({8'h00, 8'h01}, 1'b0);
    m.w(60);
    chk(16'(cmd_mode_o), 16'h0000);
    chk(16'(chs.size()), 16'h0001);
    rd(2);
    chk(lot(0), ew(3'h0));
    $display("command test done");
    wr({8'h00, 8'h02}, 1'b1);
    m.w(40);
    // Frozen cycles must not count towards the command timeout.
    ce_i = 1'b0;
    m.w(100);
    ce_i = 1'b1;
    m.w(TMO - 80);
    chk(16'(cmd_mode_o), 16'h0001);
    m.w(80);
    chk(16'(cmd_mode_o), 16'h0000);
    m.stop();
    wr({8'h00, 8'h13}, 1'b1);
    m.w(50);
    wr({8'h00, 8'h04, 8'h01}, 1'b1);
    m.w(50);
    rd(4);
    chk(lot(0), ew(3'h2));
    chk(lot(1), ew(3'h2));
    wr({8'h08, 8'h01}, 1'b0);
    chk(16'(auto_mode_o), 16'h0001);
    $display("timeout and resequence test done");
    final_report();
  end
endmodule
